// *** logic/twtc_pkg.sv ***
// Constants, state encoding and the state record of the two-wire target controller.
// Assumes one 100 MHz clock; bus pins are sampled through synchronisers in the top module.

`default_nettype none

package twtc_pkg;

	// Register offsets.
	localparam logic [3:0] TWTC_OFS_CTRL_MAIN = 4'h9;
	localparam logic [3:0] TWTC_OFS_CMD_CTRL  = 4'hA;
	localparam logic [3:0] TWTC_OFS_STATUS    = 4'hB;
	localparam logic [3:0] TWTC_OFS_OWN_ADDR  = 4'hC;
	localparam logic [3:0] TWTC_OFS_DATA      = 4'hD;

	// Main control fields.
	localparam int TWTC_CM_DATA_IRQ_EN = 7;
	localparam int TWTC_CM_AS_IRQ_EN   = 6;
	localparam int TWTC_CM_STOP_IRQ_EN = 5;
	localparam int TWTC_CM_PROMISC     = 2;
	localparam int TWTC_CM_SMART       = 1;
	localparam int TWTC_CM_ENABLE      = 0;
	localparam logic [7:0] TWTC_CM_WRITE_MASK = 8'hE7;

	// Command control fields.
	localparam int TWTC_CC_ACK_ACTION = 2;
	localparam int TWTC_CC_CMD_MSB    = 1;

	// Status fields.
	localparam int TWTC_ST_COLLISION_FLAG   = 3;
	localparam int TWTC_ST_BUS_ERROR_FLAG = 2;

	// Reset value shared by every register.
	localparam logic [7:0] TWTC_RST_BYTE = 8'h00;

	// Command codes.
	localparam logic [1:0] TWTC_CMD_NO_ACTION = 2'h0;
	localparam logic [1:0] TWTC_CMD_RESERVED  = 2'h1;
	localparam logic [1:0] TWTC_CMD_COMPLETE  = 2'h2;
	localparam logic [1:0] TWTC_CMD_RESPONSE  = 2'h3;

	// Bits in one byte, and the general call address.
	localparam logic [3:0] TWTC_BYTE_BITS    = 4'h8;
	localparam logic [6:0] TWTC_GENERAL_CALL = 7'h00;

	typedef enum logic [3:0] {
		TWTC_IDLE,
		TWTC_ADDR,
		TWTC_HOLD_ADDR,
		TWTC_ACK_OUT,
		TWTC_RX,
		TWTC_HOLD_DATA,
		TWTC_TX,
		TWTC_TX_ACK
	} twtc_state_e;

	typedef struct packed {
		logic        scl_meta;
		logic        scl_sync;
		logic        scl_prev;
		logic        sda_meta;
		logic        sda_sync;
		logic        sda_prev;
		twtc_state_e state;
		twtc_state_e ack_then;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic        selected;
		logic [7:0]  ctrl_main;
		logic        ack_action;
		logic [7:0]  own_addr;
		logic [7:0]  data;
		logic        data_flag;
		logic        addr_stop_flag;
		logic        received_ack_bit;
		logic        collision_flag;
		logic        bus_error_flag;
		logic        dir;
		logic        addr_stop_cause;
		logic        scl_oe;
		logic        sda_oe;
		logic [7:0]  rdata;
		logic        data_irq;
		logic        addr_stop_irq;
	} twtc_state_s;

endpackage

`default_nettype wire

// *** logic/twtc_top.sv ***
// Two-wire bus target controller: address match, clock stretching, byte transfer and registers.
// Assumes an external bus controller on SCL/SDA (open drain, pulled up outside) running at least
// four times slower than clk_i, and software on a plain single-cycle register port.
//
// The address-and-strobe port is this design's own decision.

`default_nettype none

module twtc_top (
	// Clock and reset.
	input  wire  logic       clk_i,
	input  wire  logic       rst_n_i,
	// Register port.
	input  wire  logic [3:0] addr_i,
	input  wire  logic [7:0] wdata_i,
	input  wire  logic       wr_i,
	input  wire  logic       rd_i,
	output var   logic [7:0] rdata_o,
	// System status.
	input  wire  logic       global_irq_enable_i,
	input  wire  logic       controller_enable_i,
	// Interrupt requests.
	output var   logic       data_irq_o,
	output var   logic       addr_stop_irq_o,
	// Bus pins.
	input  wire  logic       scl_i,
	output var   logic       scl_o,
	output var   logic       scl_oe_o,
	input  wire  logic       sda_i,
	output var   logic       sda_o,
	output var   logic       sda_oe_o
);

	twtc_pkg::twtc_state_s r_reg;
	twtc_pkg::twtc_state_s r_next;

	// Starts an acknowledge action: SDA is pulled low for ACK and SCL is let go.
	function automatic twtc_pkg::twtc_state_s begin_ack(input twtc_pkg::twtc_state_s s, input logic nack,
		input twtc_pkg::twtc_state_e then_state);
		twtc_pkg::twtc_state_s t;
		t          = s;
		t.sda_oe   = ~nack;
		t.scl_oe   = 1'b0;
		t.state    = twtc_pkg::TWTC_ACK_OUT;
		t.ack_then = then_state;
		return t;
	endfunction

	// Starts sending one byte; the first bit is driven in the same cycle as SCL is let go.
	function automatic twtc_pkg::twtc_state_s begin_tx(input twtc_pkg::twtc_state_s s, input logic [7:0] b);
		twtc_pkg::twtc_state_s t;
		t        = s;
		t.shreg  = b;
		t.sda_oe = ~b[7];
		t.scl_oe = 1'b0;
		t.bitcnt = 4'h0;
		t.state  = twtc_pkg::TWTC_TX;
		return t;
	endfunction

	always_comb begin
		logic       wr_main;
		logic       wr_cmd;
		logic       wr_stat;
		logic       dat_rd;
		logic       dat_wr;
		logic       ack_eff;
		logic [1:0] cmd;
		logic       cmd_go;
		logic       smart;
		logic       scl_rise;
		logic       scl_fall;
		logic       bus_start;
		logic       bus_stop;
		logic       mid_byte;
		logic       match;
		logic [7:0] tx_byte;
		r_next    = r_reg;
		wr_main   = wr_i && (addr_i == twtc_pkg::TWTC_OFS_CTRL_MAIN);
		wr_cmd    = wr_i && (addr_i == twtc_pkg::TWTC_OFS_CMD_CTRL);
		wr_stat   = wr_i && (addr_i == twtc_pkg::TWTC_OFS_STATUS);
		dat_rd    = rd_i && (addr_i == twtc_pkg::TWTC_OFS_DATA);
		dat_wr    = wr_i && (addr_i == twtc_pkg::TWTC_OFS_DATA);
		ack_eff   = wr_cmd ? wdata_i[twtc_pkg::TWTC_CC_ACK_ACTION] : r_reg.ack_action;
		cmd       = wr_cmd ? wdata_i[twtc_pkg::TWTC_CC_CMD_MSB:0] : twtc_pkg::TWTC_CMD_NO_ACTION;
		cmd_go    = cmd[1];
		smart     = r_reg.ctrl_main[twtc_pkg::TWTC_CM_SMART];
		tx_byte   = dat_wr ? wdata_i : r_reg.data;
		scl_rise  = r_reg.scl_sync & ~r_reg.scl_prev;
		scl_fall  = ~r_reg.scl_sync & r_reg.scl_prev;
		bus_start = r_reg.scl_sync & r_reg.scl_prev & r_reg.sda_prev & ~r_reg.sda_sync;
		bus_stop  = r_reg.scl_sync & r_reg.scl_prev & ~r_reg.sda_prev & r_reg.sda_sync;
		mid_byte  = (r_reg.state == twtc_pkg::TWTC_ADDR) || (r_reg.state == twtc_pkg::TWTC_RX)
			|| (r_reg.state == twtc_pkg::TWTC_TX);
		// A start or stop on a byte boundary is legal, except a stop right after a start, so only partial bytes count here.
		mid_byte  = mid_byte && (r_reg.bitcnt != twtc_pkg::TWTC_BYTE_BITS) && (r_reg.bitcnt != 4'h0);
		match     = r_reg.ctrl_main[twtc_pkg::TWTC_CM_PROMISC]
			|| (r_reg.shreg[7:1] == r_reg.own_addr[7:1])
			|| (r_reg.own_addr[0] && (r_reg.shreg[7:1] == twtc_pkg::TWTC_GENERAL_CALL));

		// Pin synchronisers.
		r_next.scl_meta = scl_i;
		r_next.scl_sync = r_reg.scl_meta;
		r_next.scl_prev = r_reg.scl_sync;
		r_next.sda_meta = sda_i;
		r_next.sda_sync = r_reg.sda_meta;
		r_next.sda_prev = r_reg.sda_sync;

		// Register writes and software clears; hardware sets below override them.
		if (wr_main) begin
			r_next.ctrl_main = wdata_i & twtc_pkg::TWTC_CM_WRITE_MASK;
		end
		if (wr_cmd) begin
			r_next.ack_action = wdata_i[twtc_pkg::TWTC_CC_ACK_ACTION];
		end
		if (wr_i && (addr_i == twtc_pkg::TWTC_OFS_OWN_ADDR)) begin
			r_next.own_addr = wdata_i;
		end
		if (dat_wr) begin
			r_next.data = wdata_i;
		end
		if (wr_stat && wdata_i[twtc_pkg::TWTC_ST_COLLISION_FLAG]) begin
			r_next.collision_flag = 1'b0;
		end
		if (wr_stat && wdata_i[twtc_pkg::TWTC_ST_BUS_ERROR_FLAG]) begin
			r_next.bus_error_flag = 1'b0;
		end
		if (dat_rd || dat_wr || cmd_go) begin
			r_next.data_flag      = 1'b0;
			r_next.addr_stop_flag = 1'b0;
		end

		// Read data stands only in the cycle after the strobe.
		r_next.rdata = twtc_pkg::TWTC_RST_BYTE;
		if (rd_i) begin
			case (addr_i)
				twtc_pkg::TWTC_OFS_CTRL_MAIN: r_next.rdata = r_reg.ctrl_main;
				twtc_pkg::TWTC_OFS_CMD_CTRL:  r_next.rdata = {5'h00, r_reg.ack_action, 2'h0};
				twtc_pkg::TWTC_OFS_STATUS:    r_next.rdata = {r_reg.data_flag, r_reg.addr_stop_flag, r_reg.scl_oe,
					r_reg.received_ack_bit, r_reg.collision_flag, r_reg.bus_error_flag, r_reg.dir,
					r_reg.addr_stop_cause};
				twtc_pkg::TWTC_OFS_OWN_ADDR:  r_next.rdata = r_reg.own_addr;
				twtc_pkg::TWTC_OFS_DATA:      r_next.rdata = r_reg.data;
				default:                      r_next.rdata = twtc_pkg::TWTC_RST_BYTE;
			endcase
		end

		// Byte engine.
		case (r_reg.state)
			twtc_pkg::TWTC_IDLE: begin
			end
			twtc_pkg::TWTC_ADDR, twtc_pkg::TWTC_RX: begin
				if (scl_rise) begin
					r_next.shreg  = {r_reg.shreg[6:0], r_reg.sda_sync};
					r_next.bitcnt = 4'(r_reg.bitcnt + 4'h1);
				end else if (scl_fall && (r_reg.bitcnt == twtc_pkg::TWTC_BYTE_BITS)) begin
					r_next.scl_oe = 1'b1;
					if (r_reg.state == twtc_pkg::TWTC_RX) begin
						r_next.data      = r_reg.shreg;
						r_next.data_flag = 1'b1;
						r_next.state     = twtc_pkg::TWTC_HOLD_DATA;
					end else if (match) begin
						r_next.addr_stop_flag  = 1'b1;
						r_next.addr_stop_cause = 1'b1;
						r_next.dir             = r_reg.shreg[0];
						r_next.selected        = 1'b1;
						r_next.state           = twtc_pkg::TWTC_HOLD_ADDR;
					end else begin
						r_next.scl_oe = 1'b0;
						r_next.state  = twtc_pkg::TWTC_IDLE;
					end
				end
			end
			twtc_pkg::TWTC_HOLD_ADDR: begin
				if (cmd == twtc_pkg::TWTC_CMD_RESPONSE || (smart && dat_rd)) begin
					r_next = begin_ack(r_next, ack_eff,
						r_reg.dir ? twtc_pkg::TWTC_HOLD_DATA : twtc_pkg::TWTC_RX);
				end else if (cmd == twtc_pkg::TWTC_CMD_COMPLETE) begin
					if (r_reg.dir) begin
						r_next.scl_oe = 1'b0;
						r_next.state  = twtc_pkg::TWTC_IDLE;
					end else begin
						r_next = begin_ack(r_next, ack_eff, twtc_pkg::TWTC_IDLE);
					end
				end
			end
			twtc_pkg::TWTC_HOLD_DATA: begin
				if (r_reg.dir) begin
					if (cmd == twtc_pkg::TWTC_CMD_RESPONSE || (smart && (dat_rd || dat_wr))) begin
						r_next = begin_tx(r_next, tx_byte);
					end else if (cmd == twtc_pkg::TWTC_CMD_COMPLETE) begin
						r_next.scl_oe = 1'b0;
						r_next.state  = twtc_pkg::TWTC_IDLE;
					end
				end else begin
					if (cmd == twtc_pkg::TWTC_CMD_RESPONSE || (smart && dat_rd)) begin
						r_next = begin_ack(r_next, ack_eff, twtc_pkg::TWTC_RX);
					end else if (cmd == twtc_pkg::TWTC_CMD_COMPLETE) begin
						r_next = begin_ack(r_next, ack_eff, twtc_pkg::TWTC_IDLE);
					end
				end
			end
			twtc_pkg::TWTC_ACK_OUT: begin
				if (scl_rise && !r_reg.sda_oe && !r_reg.sda_sync) begin
					r_next.collision_flag = 1'b1;
				end else if (scl_fall) begin
					r_next.sda_oe = 1'b0;
					r_next.bitcnt = 4'h0;
					r_next.shreg  = twtc_pkg::TWTC_RST_BYTE;
					r_next.state  = r_reg.ack_then;
					if (r_reg.ack_then == twtc_pkg::TWTC_HOLD_DATA) begin
						r_next.data_flag = 1'b1;
						r_next.scl_oe    = 1'b1;
					end
				end
			end
			twtc_pkg::TWTC_TX: begin
				if (scl_rise) begin
					r_next.bitcnt = 4'(r_reg.bitcnt + 4'h1);
					if (!r_reg.sda_oe && !r_reg.sda_sync) begin
						r_next.collision_flag = 1'b1;
					end
				end else if (scl_fall) begin
					r_next.shreg = {r_reg.shreg[6:0], 1'b0};
					if (r_reg.bitcnt == twtc_pkg::TWTC_BYTE_BITS) begin
						r_next.sda_oe = 1'b0;
						r_next.state  = twtc_pkg::TWTC_TX_ACK;
					end else begin
						// After a lost bit the target stops driving for the rest of the byte.
						r_next.sda_oe = ~r_reg.shreg[6] & ~r_reg.collision_flag;
					end
				end
			end
			twtc_pkg::TWTC_TX_ACK: begin
				if (scl_rise) begin
					r_next.received_ack_bit = r_reg.sda_sync;
				end else if (scl_fall) begin
					r_next.data_flag = 1'b1;
					r_next.scl_oe    = 1'b1;
					r_next.state     = twtc_pkg::TWTC_HOLD_DATA;
				end
			end
			default: begin
				r_next.state = twtc_pkg::TWTC_IDLE;
			end
		endcase

		// Start and stop conditions take priority over the byte engine.
		if (bus_start || bus_stop) begin
			if (controller_enable_i && (mid_byte || (bus_stop && r_reg.state == twtc_pkg::TWTC_ADDR
				&& r_reg.bitcnt == 4'h0))) begin
				r_next.bus_error_flag = 1'b1;
			end
			if (bus_stop && r_reg.selected && r_reg.ctrl_main[twtc_pkg::TWTC_CM_STOP_IRQ_EN]) begin
				r_next.addr_stop_flag  = 1'b1;
				r_next.addr_stop_cause = 1'b0;
			end
			if (bus_start) begin
				r_next.collision_flag = 1'b0;
			end
			r_next.selected = 1'b0;
			r_next.sda_oe   = 1'b0;
			r_next.scl_oe   = 1'b0;
			r_next.bitcnt   = 4'h0;
			r_next.state    = bus_start ? twtc_pkg::TWTC_ADDR : twtc_pkg::TWTC_IDLE;
		end

		if (!r_next.ctrl_main[twtc_pkg::TWTC_CM_ENABLE]) begin
			r_next.state    = twtc_pkg::TWTC_IDLE;
			r_next.selected = 1'b0;
			r_next.sda_oe   = 1'b0;
			r_next.scl_oe   = 1'b0;
		end

		r_next.data_irq = r_next.ctrl_main[twtc_pkg::TWTC_CM_DATA_IRQ_EN] & r_next.data_flag
			& global_irq_enable_i;
		r_next.addr_stop_irq = r_next.ctrl_main[twtc_pkg::TWTC_CM_AS_IRQ_EN] & r_next.addr_stop_flag
			& global_irq_enable_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_reg          <= '0;
			r_reg.scl_meta <= 1'b1;
			r_reg.scl_sync <= 1'b1;
			r_reg.scl_prev <= 1'b1;
			r_reg.sda_meta <= 1'b1;
			r_reg.sda_sync <= 1'b1;
			r_reg.sda_prev <= 1'b1;
			r_reg.state    <= twtc_pkg::TWTC_IDLE;
			r_reg.ack_then <= twtc_pkg::TWTC_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// Open-drain pins only ever pull low.
	assign scl_o           = 1'b0;
	assign sda_o           = 1'b0;
	assign scl_oe_o        = r_reg.scl_oe;
	assign sda_oe_o        = r_reg.sda_oe;
	assign rdata_o         = r_reg.rdata;
	assign data_irq_o      = r_reg.data_irq;
	assign addr_stop_irq_o = r_reg.addr_stop_irq;

endmodule

`default_nettype wire

// *** verification/twtc_assertions.sv ***
// Port-level checker for the two-wire target controller.
// Sees only the top module's ports; enable and smart mode are shadowed from observed writes.
`default_nettype none
module twtc_assertions (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       global_irq_enable_i,
	input wire logic       data_irq_o,
	input wire logic       addr_stop_irq_o,
	input wire logic       scl_o,
	input wire logic       scl_oe_o,
	input wire logic       sda_o,
	input wire logic       sda_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic en_reg;
	logic smart_reg;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			en_reg <= 1'b0;
			smart_reg <= 1'b0;
		end else if (wr_i && addr_i == 4'h9) begin
			en_reg <= wdata_i[0];
			smart_reg <= wdata_i[1];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	pins_low_a: assert property (!scl_o && !sda_o) else $error("pin level not low");
	disabled_quiet_a: assert property ((!en_reg)[*3] |-> !scl_oe_o && !sda_oe_o)
		else $error("drive while disabled");
	irq_gate_a: assert property (!global_irq_enable_i |=> !data_irq_o && !addr_stop_irq_o)
		else $error("irq without global enable");
	hold_status_a: assert property (rd_i && addr_i == 4'hB |=> rdata_o[5] == $past(scl_oe_o))
		else $error("clock hold bit wrong");
	cmd_readback_a: assert property (rd_i && addr_i == 4'hA |=> rdata_o[1:0] == 2'h0)
		else $error("command field not zero");
	noop_hold_a: assert property (wr_i && addr_i == 4'hA && !wdata_i[1] && scl_oe_o |=> scl_oe_o[*2])
		else $error("no-action released clock");
	cmd_release_a: assert property (wr_i && addr_i == 4'hA && wdata_i[1] && scl_oe_o |-> ##[1:3] !scl_oe_o)
		else $error("command kept clock");
	plain_data_a: assert property ((wr_i || rd_i) && addr_i == 4'hD && !smart_reg && scl_oe_o |=> scl_oe_o)
		else $error("data access resumed");
	rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside slot");
	cover property ($rose(scl_oe_o));
	cover property ($rose(data_irq_o));
	cover property ($rose(addr_stop_irq_o));
endmodule
bind twtc_top twtc_assertions u_chk (.*);
`default_nettype wire

// *** verification/twtc_bus_master.sv ***
// Behavioural bus controller driving SCL and SDA as open-drain lines.
// Assumes the bench resolves both wires with pull-ups; the bench calls its tasks.
`default_nettype none
module twtc_bus_master (
	// Resolved wires.
	input  wire logic scl_i,
	input  wire logic sda_i,
	// Pull-down enables.
	output var  logic scl_oe_o,
	output var  logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	// One bit: SDA set mid-low, SCL released and waited for while stretched.
	task automatic bit_clk(input logic b, output logic s);
		sda_oe_o = !b;
		#40;
		scl_oe_o = 1'b0;
		for (int i = 0; i < 4000 && !scl_i; i++)
			#10;
		#40;
		s = sda_i;
		#40;
		scl_oe_o = 1'b1;
		#40;
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--)
			bit_clk(d[i], q[i]);
	endtask
	task automatic start();
		sda_oe_o = 1'b1;
		#80;
		scl_oe_o = 1'b1;
		#40;
	endtask
	task automatic stop();
		sda_oe_o = 1'b1;
		#40;
		scl_oe_o = 1'b0;
		#80;
		sda_oe_o = 1'b0;
		#80;
	endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench: register port tasks, bus controller model, status model.
// Assumes the controller model above and one 100 MHz clock.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       global_irq_enable_i = 1'b1;
	logic       controller_enable_i = 1'b0;
	logic [7:0] rdata_o, q, v, own;
	logic       data_irq_o, addr_stop_irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl, m_sda, s;
	logic       m_rx = 1'b0;
	logic       m_dir = 1'b0;
	logic [7:0] mq[$];
	int         bad_count = 0;
	int         n_compared = 0;
	int         cyc = 0;
	wire        scl_w = !(scl_oe_o | m_scl);
	wire        sda_w = !(sda_oe_o | m_sda);
	always #5 clk_i = !clk_i;
	twtc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .global_irq_enable_i(global_irq_enable_i),
		.controller_enable_i(controller_enable_i), .data_irq_o(data_irq_o), .addr_stop_irq_o(addr_stop_irq_o),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
	twtc_bus_master u_mst (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			results();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// Status from the model; the cause bit means nothing while its flag is clear.
	task automatic st(input logic [7:0] f);
		f = f | {3'h0, m_rx, 2'h0, m_dir, 1'b0};
		rd(4'hB, q);
		if (!f[6])
			q[0] = 1'b0;
		chk("status", f, q);
	endtask
	task automatic hold();
		for (int i = 0; i < 100 && !scl_oe_o; i++)
			@(posedge clk_i);
		repeat (2) @(posedge clk_i);
	endtask
	initial begin
		v = $urandom(32'h0a9c);
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		for (int a = 9; a <= 13; a++) begin
			rd(a[3:0], q);
			chk("reset value", 8'h00, q);
		end
		v = $urandom();
		wr(4'h9, v);
		rd(4'h9, q);
		chk("main control", v & 8'he7, q);
		wr(4'hA, 8'h05);
		rd(4'hA, q);
		chk("command control", 8'h04, q);
		wr(4'hA, 8'h00);
		own = ($urandom() | 8'h02) & 8'hfe;
		wr(4'h2, own);
		rd(4'h2, q);
		chk("unmapped", 8'h00, q);
		wr(4'h9, 8'he1);
		wr(4'hC, own);
		$display("registers done");
		u_mst.start();
		u_mst.xfer(own ^ 8'h02, q);
		repeat (10) @(posedge clk_i);
		chk("no stretch", 8'h00, {7'h00, scl_oe_o});
		u_mst.bit_clk(1'b1, s);
		chk("foreign nack", 8'h01, {7'h00, s});
		u_mst.stop();
		st(8'h00);
		$display("foreign address done");
		for (int p = 0; p < 2; p++) begin
			wr(4'hC, own | p[7:0]);
			u_mst.start();
			u_mst.xfer(p ? 8'h00 : own, q);
			hold();
			st(8'h61);
			chk("addr irq", 8'h01, {7'h00, addr_stop_irq_o});
			global_irq_enable_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			chk("gated irq", 8'h00, {7'h00, addr_stop_irq_o});
			global_irq_enable_i <= 1'b1;
			wr(4'hA, 8'h00);
			wr(4'hA, 8'h01);
			st(8'h61);
			fork
				u_mst.bit_clk(1'b1, s);
				wr(4'hA, 8'h03);
			join
			chk("ack", 8'h00, {7'h00, s});
			v = $urandom();
			mq.push_back(v);
			u_mst.xfer(v, q);
			hold();
			st(8'ha0);
			chk("data irq", 8'h01, {7'h00, data_irq_o});
			rd(4'hD, q);
			chk("rx data", mq.pop_front(), q);
			fork
				u_mst.bit_clk(1'b1, s);
				wr(4'hA, 8'h06);
			join
			chk("nack", 8'h01, {7'h00, s});
			u_mst.stop();
			repeat (10) @(posedge clk_i);
			st(8'h40);
			rd(4'hD, q);
			st(8'h00);
			$display("write pass %0d done", p);
		end
		wr(4'h9, 8'he7);
		v = $urandom() | 8'h01;
		u_mst.start();
		u_mst.xfer(v, q);
		hold();
		m_dir = 1'b1;
		st(8'h61);
		fork
			u_mst.bit_clk(1'b1, s);
			wr(4'hA, 8'h03);
		join
		chk("read ack", 8'h00, {7'h00, s});
		hold();
		st(8'ha0);
		v = $urandom();
		fork
			u_mst.xfer(8'hff, q);
			wr(4'hD, v);
		join
		chk("tx data", v, q);
		u_mst.bit_clk(1'b1, s);
		m_rx = 1'b1;
		hold();
		st(8'ha0);
		fork
			u_mst.xfer(8'h00, q);
			wr(4'hD, 8'hff);
		join
		u_mst.bit_clk(1'b1, s);
		hold();
		st(8'ha8);
		wr(4'hB, 8'h08);
		st(8'ha0);
		wr(4'hA, 8'h02);
		u_mst.stop();
		repeat (10) @(posedge clk_i);
		st(8'h40);
		rd(4'hD, q);
		$display("smart read done");
		for (int m = 0; m < 2; m++) begin
			controller_enable_i <= m[0];
			u_mst.start();
			u_mst.stop();
			repeat (10) @(posedge clk_i);
			st({5'h00, m[0], 2'h0});
			wr(4'hB, 8'h04);
			st(8'h00);
		end
		$display("bus error done");
		wr(4'h9, 8'he0);
		u_mst.start();
		u_mst.xfer(own, q);
		repeat (10) @(posedge clk_i);
		u_mst.bit_clk(1'b1, s);
		chk("disabled nack", 8'h01, {7'h00, s});
		u_mst.stop();
		st(8'h00);
		$display("disabled done");
		results();
	end
endmodule
`default_nettype wire
